// *** rtl/spm_blink.v ***
// activity blinker: turns activity events into a slow on/off phase
`timescale 1ns/100ps
`include "spm_regs.vh"

module spm_blink #(
	parameter HALF = 2500000
) (
	// clock and reset
	input  wire aclk,
	input  wire aresetn,
	// activity in, blink out
	input  wire event_in,
	output reg  busy_reg,
	output reg  phase_reg
);

	localparam integer LAST = HALF - 1;

	reg [`SPM_BLINK_CNT_W-1:0] cnt_reg;
	reg                        pend_reg;

	// one blink period per burst of activity, retriggered while events keep coming
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg   <= {`SPM_BLINK_CNT_W{1'b0}};
			busy_reg  <= 1'b0;
			phase_reg <= 1'b0;
			pend_reg  <= 1'b0;
		end else if (busy_reg) begin
			if (cnt_reg == LAST[`SPM_BLINK_CNT_W-1:0]) begin
				cnt_reg   <= {`SPM_BLINK_CNT_W{1'b0}};
				phase_reg <= ~phase_reg;
				// close only after the low half, so a blink is high then low
				if (!phase_reg) begin
					busy_reg <= pend_reg | event_in;
					pend_reg <= 1'b0; // absorbed by the retrigger
				end else begin
					pend_reg <= pend_reg | event_in;
				end
			end else begin
				cnt_reg  <= cnt_reg + 1'b1;
				pend_reg <= pend_reg | event_in;
			end
		end else if (event_in) begin
			busy_reg  <= 1'b1;
			phase_reg <= 1'b1;
			cnt_reg   <= {`SPM_BLINK_CNT_W{1'b0}};
			pend_reg  <= 1'b0;
		end
	end

endmodule // spm_blink

// *** rtl/spm_regs.vh ***
// register offsets, field positions, reset values and timing counts of the strap pin mux
`ifndef SPM_REGS_VH
`define SPM_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define SPM_CTRL_OFS     8'h00
`define SPM_LEDSEL_OFS   8'h04
`define SPM_STIO_OFS     8'h08
`define SPM_MBIO_OFS     8'h0C
`define SPM_GPIO_OFS     8'h10
`define SPM_STAT_OFS     8'h14

// ****************************************
// field positions
// ****************************************
`define SPM_CTRL_IFSEL   0
`define SPM_CTRL_REFOUT  1
`define SPM_CTRL_PMESEL  12

// ****************************************
// reset values
// ****************************************
`define SPM_CTRL_RST     32'h00000000
`define SPM_LEDSEL_RST   32'h000000E4
`define SPM_STIO_RST     32'h00000000
`define SPM_MBIO_RST     32'h00000000
`define SPM_GPIO_RST     32'h00000000

// ****************************************
// responses
// ****************************************
`define SPM_RESP_OKAY    2'h0
`define SPM_RESP_DECERR  2'h3

// ****************************************
// timing
// ****************************************
`define SPM_CLK_NS        20
`define SPM_BLINK_HALF_NS 50000000
`define SPM_BLINK_CNT_W   22

`endif

// *** rtl/spm_top.v ***
// strap capture, multi-function pin mux and status leds with an axi4-lite register file
//
// Operation
// - capture strap levels during reset, configure pins
// - link/usb straps pick internal, rmii, reverse
// - eeprom clock strap one forces usb full
// - gpio1 strap one enters wake-on-lan ready
// - gpio0 is io unless flag 12 selects event
// - link strap one: media pins all gpio
// - media pin 0 always gpio with enable
// - usb strap picks rmii or reverse rmii
// - rmii pin order crsdv txen txd1 txd0 ref rxd
// - reference clock direction from flag bit 1
// - speed pin mdio, duplex pin mdc when external
// - usb led floats full speed, low high
// - usb led blinks on bulk-out traffic
// - link led low when up, blinks traffic
// - speed led low 100, high 10
// - duplex led low full, high half
// - duplex led blinks on half duplex collision
// - status pins reselectable led source or gpio
// - event output shows detected wakeup
// - mac mode path select internal phy or rmii
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "spm_regs.vh"

module spm_top #(
	parameter BLINK_HALF = `SPM_BLINK_HALF_NS / `SPM_CLK_NS
) (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// status pins: duplex, speed, link, usb
	input  wire [3:0]  status_pin_i,
	output reg  [3:0]  status_pin_o,
	output reg  [3:0]  status_pin_oe,
	// media pins 0..7
	input  wire [7:0]  media_pin_i,
	output reg  [7:0]  media_pin_o,
	output reg  [7:0]  media_pin_oe,
	// general purpose pins 0 and 1
	input  wire [1:0]  gp_pin_i,
	output reg  [1:0]  gp_pin_o,
	output reg  [1:0]  gp_pin_oe,
	// eeprom clock pin, read as strap only
	input  wire        eeprom_clock_strap,
	// led sources from usb core and phy
	input  wire        usb_high_speed,
	input  wire        usb_bulk_out,
	input  wire        eth_link_up,
	input  wire        eth_activity,
	input  wire        eth_speed_100,
	input  wire        eth_full_duplex,
	input  wire        eth_collision,
	input  wire        wake_event,
	// mac core datapath
	input  wire        core_tx_en,
	input  wire [1:0]  core_txd,
	output reg         core_rx_dv,
	output reg  [1:0]  core_rxd,
	// internal phy datapath
	output reg         iphy_tx_en,
	output reg  [1:0]  iphy_txd,
	input  wire        iphy_rx_dv,
	input  wire [1:0]  iphy_rxd,
	// station management from and to the core
	input  wire        sta_mdc_o,
	input  wire        sta_mdio_o,
	input  wire        sta_mdio_oe,
	output reg         sta_mdc_i,
	output reg         sta_mdio_i,
	// captured configuration
	output reg         force_usb_full_speed,
	output reg         wol_ready_mode,
	output reg         mac_not_phy_strap,
	output reg         ext_media_active
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	localparam NIN = 15;

	wire [NIN-1:0] raw_in = {eeprom_clock_strap, gp_pin_i, media_pin_i, status_pin_i};
	reg  [NIN-1:0] meta_reg;
	reg  [NIN-1:0] sync_reg;

	// two flops, no reset so straps are seen while reset is held
	always @(posedge aclk) begin
		meta_reg <= raw_in;
		sync_reg <= meta_reg;
	end

	wire [3:0] st_in   = sync_reg[3:0];
	wire [7:0] md_in   = sync_reg[11:4];
	wire [1:0] gp_in   = sync_reg[13:12];
	wire       eeprom_clock_strap_in = sync_reg[14];

	// ****************************************
	// strap capture
	// ****************************************
	reg strap_link_reg;
	reg strap_usb_reg;
	reg strap_eeprom_clock_strap_reg;
	reg strap_gp1_reg;

	// sample while reset is low, frozen afterwards
	always @(posedge aclk) begin
		if (!aresetn) begin
			strap_link_reg <= st_in[2];
			strap_usb_reg  <= st_in[3];
			strap_eeprom_clock_strap_reg <= eeprom_clock_strap_in;
			strap_gp1_reg  <= gp_in[1];
		end
	end

	wire ext_en   = ~strap_link_reg;
	wire rmii_md  = ext_en & strap_usb_reg;
	wire rev_md   = ext_en & ~strap_usb_reg;

	// ****************************************
	// register file
	// ****************************************
	reg [31:0] ctrl_reg;
	reg [31:0] ledsel_reg;
	reg [31:0] stio_reg;
	reg [31:0] mbio_reg;
	reg [31:0] gpio_reg;
	reg        ref_seen_reg;
	reg        ref_div_reg;
	reg        ref_prev_reg;

	wire ext_path = rev_md | (rmii_md & ctrl_reg[`SPM_CTRL_IFSEL]);
	wire ref_out  = ctrl_reg[`SPM_CTRL_REFOUT];
	wire pme_sel  = ctrl_reg[`SPM_CTRL_PMESEL];

	reg        aw_hold_reg;
	reg [7:0]  awaddr_reg;
	reg        w_hold_reg;
	reg [31:0] wdata_reg;
	reg [3:0]  wstrb_reg;

	assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
		{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	wire        do_wr = aw_hold_reg & w_hold_reg;

	// write channel: address and data in either order, response after both
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg  <= 1'b0;
			w_hold_reg   <= 1'b0;
			awaddr_reg   <= 8'h00;
			wdata_reg    <= 32'h00000000;
			wstrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SPM_RESP_OKAY;
			ctrl_reg     <= `SPM_CTRL_RST;
			ledsel_reg   <= `SPM_LEDSEL_RST;
			stio_reg     <= `SPM_STIO_RST;
			mbio_reg     <= `SPM_MBIO_RST;
			gpio_reg     <= `SPM_GPIO_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `SPM_RESP_OKAY;
				case (awaddr_reg)
				`SPM_CTRL_OFS:   ctrl_reg   <= (ctrl_reg & ~wmask) | (wdata_reg & wmask);
				`SPM_LEDSEL_OFS: ledsel_reg <= (ledsel_reg & ~wmask) | (wdata_reg & wmask);
				`SPM_STIO_OFS:   stio_reg   <= (stio_reg & ~wmask) | (wdata_reg & wmask);
				`SPM_MBIO_OFS:   mbio_reg   <= (mbio_reg & ~wmask) | (wdata_reg & wmask);
				`SPM_GPIO_OFS:   gpio_reg   <= (gpio_reg & ~wmask) | (wdata_reg & wmask);
				`SPM_STAT_OFS:   s_axi_bresp <= `SPM_RESP_OKAY; // read only, ignored
				default:         s_axi_bresp <= `SPM_RESP_DECERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel: one cycle to data, held until taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `SPM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `SPM_RESP_OKAY;
			case (s_axi_araddr)
			`SPM_CTRL_OFS:   s_axi_rdata <= ctrl_reg;
			`SPM_LEDSEL_OFS: s_axi_rdata <= {20'h00000, ledsel_reg[11:0]};
			`SPM_STIO_OFS:   s_axi_rdata <= {20'h00000, st_in, stio_reg[7:0]};
			`SPM_MBIO_OFS:   s_axi_rdata <= {8'h00, md_in, mbio_reg[15:0]};
			`SPM_GPIO_OFS:   s_axi_rdata <= {22'h000000, gp_in, 2'h0, gpio_reg[5:4],
				2'h0, gpio_reg[1:0]};
			`SPM_STAT_OFS:   s_axi_rdata <= {23'h000000, wake_event, ref_seen_reg,
				ext_path, rev_md, rmii_md, strap_gp1_reg, strap_eeprom_clock_strap_reg,
				strap_usb_reg, strap_link_reg};
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `SPM_RESP_DECERR;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// reference clock
	// ****************************************
	// divider drives the pin when it is an output, edge finder watches it in either direction
	always @(posedge aclk) begin
		if (!aresetn) begin
			ref_div_reg  <= 1'b0;
			ref_prev_reg <= 1'b1; // pin idles high on its pull-up
			ref_seen_reg <= 1'b0;
		end else begin
			ref_div_reg  <= ~ref_div_reg;
			ref_prev_reg <= md_in[5];
			if (md_in[5] & ~ref_prev_reg)
				ref_seen_reg <= 1'b1;
		end
	end

	// ****************************************
	// led blinkers: usb traffic, link traffic, collision
	// ****************************************
	wire [2:0] blk_evt = {eth_collision & ~eth_full_duplex, eth_activity, usb_bulk_out};
	wire [2:0] blk_busy;
	wire [2:0] blk_phase;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_blk
			spm_blink #(
				.HALF (BLINK_HALF)
			) u_blink (
				.aclk      (aclk),
				.aresetn   (aresetn),
				.event_in  (blk_evt[gi]),
				.busy_reg  (blk_busy[gi]),
				.phase_reg (blk_phase[gi])
			);
		end
	endgenerate

	// led functions as {oe, level}, index 0 duplex, 1 speed, 2 link, 3 usb
	wire [1:0] fn_dup = {1'b1, (blk_busy[2] ? blk_phase[2] : ~eth_full_duplex)};
	wire [1:0] fn_spd = {1'b1, ~eth_speed_100};
	wire [1:0] fn_lnk = {1'b1, (blk_busy[1] ? blk_phase[1] : ~eth_link_up)};
	wire [1:0] fn_usb = {(blk_busy[0] ? blk_phase[0] : usb_high_speed), 1'b0};
	wire [7:0] fn_all = {fn_usb, fn_lnk, fn_spd, fn_dup};

	// ****************************************
	// pin mux
	// ****************************************
	reg [3:0] st_o_next;
	reg [3:0] st_oe_next;
	reg [7:0] md_o_next;
	reg [7:0] md_oe_next;
	reg [1:0] gp_o_next;
	reg [1:0] gp_oe_next;
	reg [1:0] sel;
	integer   k;

	// per-pin function choice, registered below
	always @* begin
		sel = 2'h0;
		for (k = 0; k < 4; k = k + 1) begin
			sel = ledsel_reg[2*k +: 2];
			if (ledsel_reg[8+k]) begin
				st_o_next[k]  = stio_reg[k];
				st_oe_next[k] = stio_reg[4+k];
			end else begin
				st_o_next[k]  = fn_all[2*sel];
				st_oe_next[k] = fn_all[2*sel+1];
			end
		end
		if (ext_en) begin
			st_o_next[0]  = sta_mdc_o;
			st_oe_next[0] = rmii_md;
			st_o_next[1]  = sta_mdio_o;
			st_oe_next[1] = sta_mdio_oe;
		end
		md_o_next  = mbio_reg[7:0];
		md_oe_next = mbio_reg[15:8];
		if (ext_en) begin
			md_oe_next[7:1] = {2'b00, ref_out, 3'b111, 1'b0};
			md_o_next[7:1]  = {2'b00, ref_div_reg, core_txd[0], core_txd[1],
				core_tx_en, 1'b0};
		end
		gp_o_next  = gpio_reg[1:0];
		gp_oe_next = gpio_reg[5:4];
		if (pme_sel) begin
			gp_o_next[0]  = wake_event;
			gp_oe_next[0] = 1'b1;
		end
	end

	// registered pin drive and datapath steering
	always @(posedge aclk) begin
		if (!aresetn) begin
			status_pin_o  <= 4'h0;
			status_pin_oe <= 4'h0;
			media_pin_o   <= 8'h00;
			media_pin_oe  <= 8'h00;
			gp_pin_o      <= 2'h0;
			gp_pin_oe     <= 2'h0;
			core_rx_dv    <= 1'b0;
			core_rxd      <= 2'h0;
			iphy_tx_en    <= 1'b0;
			iphy_txd      <= 2'h0;
			sta_mdc_i     <= 1'b0;
			sta_mdio_i    <= 1'b0;
		end else begin
			status_pin_o  <= st_o_next;
			status_pin_oe <= st_oe_next;
			media_pin_o   <= md_o_next;
			media_pin_oe  <= md_oe_next;
			gp_pin_o      <= gp_o_next;
			gp_pin_oe     <= gp_oe_next;
			if (ext_path) begin
				core_rx_dv <= md_in[1];
				core_rxd   <= {md_in[6], md_in[7]};
				iphy_tx_en <= 1'b0;
				iphy_txd   <= 2'h0;
			end else begin
				core_rx_dv <= iphy_rx_dv;
				core_rxd   <= iphy_rxd;
				iphy_tx_en <= core_tx_en;
				iphy_txd   <= core_txd;
			end
			sta_mdc_i  <= rev_md ? st_in[0] : sta_mdc_o;
			sta_mdio_i <= st_in[1];
		end
	end

	// ****************************************
	// configuration outputs
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			force_usb_full_speed <= 1'b0;
			wol_ready_mode       <= 1'b0;
			mac_not_phy_strap    <= 1'b1;
			ext_media_active     <= 1'b0;
		end else begin
			force_usb_full_speed <= strap_eeprom_clock_strap_reg;
			wol_ready_mode       <= strap_gp1_reg;
			mac_not_phy_strap    <= strap_link_reg | strap_usb_reg;
			ext_media_active     <= ext_path;
		end
	end

endmodule // spm_top

// *** tb/spm_checker.sv ***
// assertion checker for the strap pin mux top
`timescale 1ns/100ps
module spm_checker (
	// clock and reset
	input wire		aclk,
	input wire		aresetn,
	// register bus
	input wire		s_axi_awvalid,
	input wire		s_axi_awready,
	input wire		s_axi_wvalid,
	input wire		s_axi_wready,
	input wire [1:0]	s_axi_bresp,
	input wire		s_axi_bvalid,
	input wire		s_axi_bready,
	input wire		s_axi_arvalid,
	input wire		s_axi_arready,
	input wire [31:0]	s_axi_rdata,
	input wire		s_axi_rvalid,
	input wire		s_axi_rready,
	// pins and configuration
	input wire [3:0]	status_pin_o,
	input wire [3:0]	status_pin_oe,
	input wire [7:0]	media_pin_o,
	input wire [7:0]	media_pin_oe,
	input wire [1:0]	gp_pin_oe,
	input wire		sta_mdc_o,
	input wire		force_usb_full_speed,
	input wire		wol_ready_mode,
	input wire		mac_not_phy_strap,
	input wire		ext_media_active
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// write taken on both channels, then answered
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_soon;
		##[1:2] s_axi_bvalid;
	endsequence
	a_write_answer: assert property (s_wr_taken |-> s_b_soon)
		else $error("write answer late");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_reset_quiet: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
		media_pin_oe == 8'h00 && status_pin_oe == 4'h0 && gp_pin_oe == 2'h0)
		else $error("pins driven in reset");
	a_straps_hold: assert property ($past(aresetn) && $past(aresetn, 2) |->
		$stable({force_usb_full_speed, wol_ready_mode, mac_not_phy_strap}))
		else $error("captured strap moved");
	a_ref_toggles: assert property (ext_media_active && media_pin_oe[5] && $past(media_pin_oe[5])
		|-> media_pin_o[5] != $past(media_pin_o[5]))
		else $error("ref clock output stuck");
	a_mdc_drive: assert property (ext_media_active && mac_not_phy_strap |->
		status_pin_oe[0] && status_pin_o[0] == $past(sta_mdc_o))
		else $error("mdc not driven");
endmodule // spm_checker

bind spm_top spm_checker spm_checker_inst (.*);

// *** tb/spm_rmii_far.sv ***
// far-side rmii device: receive lines, free reference clock, transmit capture
`timescale 1ns/100ps
module spm_rmii_far (
	// board pins
	input wire [7:0]	pin_o,
	input wire [7:0]	pin_oe,
	output logic [7:0]	drv,
	output logic [7:0]	drv_en,
	// receive stimulus, captured transmit
	input wire		rx_on,
	input wire [1:0]	rx_d,
	output logic [2:0]	tx_seen
);
	logic ref_clk = 1'b0;
	// free reference clock, driven only while the device pin listens
	always #80 ref_clk = ~ref_clk;
	// crsdv on 1, ref on 5, rxd1 on 6, rxd0 on 7; data released when idle
	always_comb begin
		drv = {rx_d[0], rx_d[1], ref_clk, 3'b000, rx_on, 1'b0};
		drv_en = {rx_on, rx_on, ~pin_oe[5], 3'b000, 1'b1, 1'b0};
	end
	// txen, txd1, txd0 taken on the reference clock
	always @(posedge ref_clk) tx_seen <= {pin_o[2], pin_o[3], pin_o[4]};
endmodule // spm_rmii_far

// *** tb/spm_top_tb.sv ***
// self-checking bench for the strap pin mux top
`timescale 1ns/100ps
`include "spm_regs.vh"
module spm_top_tb;
	logic		aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic		s_axi_arvalid = 0, s_axi_rready = 0, eeprom_clock_strap = 0, usb_high_speed = 0;
	logic		usb_bulk_out = 0, eth_link_up = 1, eth_activity = 0, eth_speed_100 = 0;
	logic		eth_full_duplex = 1, eth_collision = 0, wake_event = 0, core_tx_en = 0;
	logic		iphy_rx_dv = 0, rx_on = 0;
	logic [7:0]	s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0]	s_axi_wdata = 0, rd;
	logic [3:0]	s_axi_wstrb = 4'hF, st_lvl = 4'hF;
	logic [1:0]	core_txd = 0, iphy_rxd = 0, gp_lvl = 0, rx_d = 0, rr;
	logic [2:0]	sta_cnt = 0;
	wire [31:0]	s_axi_rdata;
	wire [1:0]	s_axi_bresp, s_axi_rresp, gp_pin_i, gp_pin_o, gp_pin_oe, core_rxd, iphy_txd;
	wire [3:0]	status_pin_i, status_pin_o, status_pin_oe;
	wire [7:0]	media_pin_i, media_pin_o, media_pin_oe, far_drv, far_en;
	wire [2:0]	tx_seen;
	wire		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire		core_rx_dv, iphy_tx_en, sta_mdc_i, sta_mdio_i, sta_mdc_o, sta_mdio_o;
	wire		sta_mdio_oe, force_usb_full_speed, wol_ready_mode, mac_not_phy_strap;
	wire		ext_media_active;
	int		bad_count = 0, checks = 0, cyc = 0, n;
	// pin levels: device drive, else far side or strap, else pull-up
	assign status_pin_i = (status_pin_oe & status_pin_o) | (~status_pin_oe & st_lvl);
	assign gp_pin_i = (gp_pin_oe & gp_pin_o) | (~gp_pin_oe & gp_lvl);
	assign media_pin_i = (media_pin_oe & media_pin_o) | (~media_pin_oe & (~far_en | far_drv));
	assign {sta_mdc_o, sta_mdio_o, sta_mdio_oe} = sta_cnt;
	spm_top #(.BLINK_HALF(8)) spm_top_inst (.*);
	spm_rmii_far spm_rmii_far_inst (.pin_o(media_pin_o), .pin_oe(media_pin_oe), .drv(far_drv),
		.drv_en(far_en), .rx_on(rx_on), .rx_d(rx_d), .tx_seen(tx_seen));
	// clock, management traffic, hang limit
	always #10 aclk = ~aclk;
	always @(posedge aclk) begin
		sta_cnt <= sta_cnt + 3'h1;
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			bad_count++;
			test_done;
		end
	end
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task rst(input logic [3:0] st, input logic ee, input logic [1:0] gp);
		st_lvl <= st;
		eeprom_clock_strap <= ee;
		gp_lvl <= gp;
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
	endtask
	// write: both channels offered, each released once taken
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [2:0] x;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			x = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
			rr = s_axi_bresp;
			@(posedge aclk);
			if (x[2]) s_axi_awvalid <= 1'b0;
			if (x[1]) s_axi_wvalid <= 1'b0;
		end while (!x[0]);
		s_axi_bready <= 1'b0;
		cmp("bresp", er, rr);
		repeat (4) @(posedge aclk);
	endtask
	// read with masked compare
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [1:0] x;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			x = {s_axi_arvalid & s_axi_arready, s_axi_rvalid};
			rd = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge aclk);
			if (x[1]) s_axi_arvalid <= 1'b0;
		end while (!x[0]);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		cmp(nm, e, rd & m);
	endtask
	initial begin
		// rmii mac mode, optional straps high
		rst(4'hB, 1'b1, 2'b10);
		cmp("cfg", 4'hE, {force_usb_full_speed, wol_ready_mode, mac_not_phy_strap, ext_media_active});
		rdc("ledsel", `SPM_LEDSEL_OFS, 32'hFFFFFFFF, `SPM_LEDSEL_RST);
		rdc("unmapped", 8'h18, 32'hFFFFFFFF, 32'h0);
		cmp("rresp", `SPM_RESP_DECERR, rr);
		axw(8'h20, 32'hFFFFFFFF, `SPM_RESP_DECERR);
		core_tx_en <= 1'b1;
		core_txd <= 2'b10;
		rx_on <= 1'b1;
		rx_d <= 2'b01;
		axw(`SPM_MBIO_OFS, 32'h0101, `SPM_RESP_OKAY);
		axw(`SPM_CTRL_OFS, 32'h1, `SPM_RESP_OKAY);
		repeat (30) @(posedge aclk);
		cmp("ext", 1'b1, ext_media_active);
		cmp("media oe", 8'h1D, media_pin_oe);
		cmp("media tx", 3'b011, media_pin_o[4:2]);
		cmp("core rx", 3'b101, {core_rx_dv, core_rxd});
		cmp("iphy off", 3'b000, {iphy_tx_en, iphy_txd});
		cmp("far tx", 3'b110, tx_seen);
		cmp("mdc oe", 1'b1, status_pin_oe[0]);
		axw(`SPM_CTRL_OFS, 32'h3, `SPM_RESP_OKAY);
		cmp("ref oe", 1'b1, media_pin_oe[5]);
		rdc("stat", `SPM_STAT_OFS, 32'h1FF, 32'hDE);
		st_lvl <= 4'h4;
		eeprom_clock_strap <= 1'b0;
		gp_lvl <= 2'b00;
		repeat (8) @(posedge aclk);
		cmp("held", 3'b111, {force_usb_full_speed, wol_ready_mode, mac_not_phy_strap});
		// reverse rmii phy mode
		rst(4'h3, 1'b0, 2'b00);
		cmp("cfg", 3'b000, {force_usb_full_speed, wol_ready_mode, mac_not_phy_strap});
		cmp("rev oe", 9'h01C, {status_pin_oe[0], media_pin_oe});
		rdc("stat", `SPM_STAT_OFS, 32'h3F, 32'h20);
		st_lvl <= 4'h2;
		repeat (4) @(posedge aclk);
		cmp("mdc in", 1'b0, sta_mdc_i);
		// general purpose mode with default leds
		rx_on <= 1'b0;
		rst(4'hF, 1'b0, 2'b00);
		cmp("leds", 8'h72, {status_pin_oe, status_pin_o});
		cmp("iphy", 3'b110, {iphy_tx_en, iphy_txd});
		usb_high_speed <= 1'b1;
		repeat (4) @(posedge aclk);
		cmp("usb led", 2'b10, {status_pin_oe[3], status_pin_o[3]});
		usb_bulk_out <= 1'b1;
		eth_activity <= 1'b1;
		@(posedge aclk);
		usb_bulk_out <= 1'b0;
		eth_activity <= 1'b0;
		// usb led floats in its low half, link led goes high in its high half
		rd = 32'h0;
		repeat (40) begin
			@(negedge aclk);
			rd[0] = rd[0] | status_pin_o[2];
			rd[1] = rd[1] | ~status_pin_oe[3];
		end
		cmp("blink", 2'b11, rd[1:0]);
		cmp("blink end", 2'b10, {status_pin_oe[3], status_pin_o[2]});
		@(posedge aclk);
		axw(`SPM_MBIO_OFS, 32'hFFA5, `SPM_RESP_OKAY);
		cmp("media", 16'hFFA5, {media_pin_oe, media_pin_o});
		rdc("mbio", `SPM_MBIO_OFS, 32'hFFFFFF, 32'hA5FFA5);
		axw(`SPM_LEDSEL_OFS, 32'h1E4, `SPM_RESP_OKAY);
		axw(`SPM_STIO_OFS, 32'h11, `SPM_RESP_OKAY);
		cmp("stio", 2'b11, {status_pin_oe[0], status_pin_o[0]});
		wake_event <= 1'b1;
		axw(`SPM_CTRL_OFS, 32'h1000, `SPM_RESP_OKAY);
		cmp("event", 2'b11, {gp_pin_oe[0], gp_pin_o[0]});
		test_done;
	end
endmodule // spm_top_tb
